// ==== core/bst_pkg.sv ====
// Constants, states and instruction codes for the boundary-scan test port
package bst_pkg;
  localparam int          IR_W     = 3;
  localparam int          BSR_W    = 126;
  localparam int          ID_W     = 32;
  localparam logic [2:0]  IR_EXTEST  = 3'h0;
  localparam logic [2:0]  IR_IDCODE  = 3'h1;
  localparam logic [2:0]  IR_SAMPLE  = 3'h2;
  localparam logic [2:0]  IR_CLAMP   = 3'h3;
  localparam logic [2:0]  IR_HIGHZ   = 3'h4;
  localparam logic [2:0]  IR_BYPASS  = 3'h7;
  localparam logic [2:0]  IR_CAPTURE = 3'h1;
  localparam logic        FEAT_NATIVE = 1'h0;
  // Identity fields are arbitrary neutral values
  localparam logic [3:0]  ID_VERSION = 4'h0;
  localparam logic [15:0] ID_DEVICE  = 16'h5a5a;
  localparam logic [10:0] ID_MAKER   = 11'h2aa;
  localparam logic        ID_LSB     = 1'h1;
  typedef enum logic [3:0] {
    ST_RESET  = 4'h0, ST_IDLE   = 4'h1, ST_SEL_DR = 4'h3, ST_CAP_DR = 4'h2,
    ST_SH_DR  = 4'h6, ST_EX1_DR = 4'h7, ST_PA_DR  = 4'h5, ST_EX2_DR = 4'h4,
    ST_UP_DR  = 4'hc, ST_SEL_IR = 4'hd, ST_CAP_IR = 4'hf, ST_SH_IR  = 4'he,
    ST_EX1_IR = 4'ha, ST_PA_IR  = 4'hb, ST_EX2_IR = 4'h9, ST_UP_IR  = 4'h8
  } bst_state_t;
endpackage : bst_pkg

// ==== core/bst_tap.sv ====
// Boundary-scan test access port: controller, instruction and data registers
`timescale 1ns/100ps
module bst_tap (
  // System
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    feature_set_select,
  // Test port pins
  input  wire logic                    tap_reset_pin_n,
  input  wire logic                    tap_clock_pin,
  input  wire logic                    tap_mode_select_pin,
  input  wire logic                    tap_serial_in_pin,
  output logic                         tap_serial_out_pin,
  output logic                         tap_serial_out_oe,
  // Boundary cells
  input  wire logic [bst_pkg::BSR_W-1:0] bsr_pin_in,
  input  wire logic [bst_pkg::BSR_W-1:0] bsr_func_out,
  output logic      [bst_pkg::BSR_W-1:0] bsr_pin_out,
  output logic                         pin_out_oe,
  output logic      [bst_pkg::IR_W-1:0]  current_instr
);

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [1:0] trst_s_r, tck_s_r, tms_s_r, tdi_s_r, fss_s_r;
  logic       tck_d_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trst_s_r <= 2'h0;
      tck_s_r  <= 2'h0;
      tms_s_r  <= 2'h0;
      tdi_s_r  <= 2'h0;
      // Strap reads as disabled until its synchroniser has filled
      fss_s_r  <= {2{~bst_pkg::FEAT_NATIVE}};
      tck_d_r  <= 1'h0;
    end else begin
      trst_s_r <= {trst_s_r[0], tap_reset_pin_n};
      tck_s_r  <= {tck_s_r[0], tap_clock_pin};
      tms_s_r  <= {tms_s_r[0], tap_mode_select_pin};
      tdi_s_r  <= {tdi_s_r[0], tap_serial_in_pin};
      fss_s_r  <= {fss_s_r[0], feature_set_select};
      tck_d_r  <= tck_s_r[1];
    end
  end

  logic enabled, trst_n, tck_rise, tck_fall, tms, tdi;
  assign enabled  = (fss_s_r[1] == bst_pkg::FEAT_NATIVE);
  assign trst_n   = trst_s_r[1];
  assign tck_rise = enabled & tck_s_r[1] & ~tck_d_r;
  assign tck_fall = enabled & ~tck_s_r[1] & tck_d_r;
  assign tms      = tms_s_r[1];
  assign tdi      = tdi_s_r[1];

  // ****************************************
  // Controller
  // ****************************************
  bst_pkg::bst_state_t state_r, state_nxt;
  always_comb begin
    state_nxt = state_r;
    if (tck_rise) begin
      unique case (state_r)
        bst_pkg::ST_RESET:  state_nxt = tms ? bst_pkg::ST_RESET  : bst_pkg::ST_IDLE;
        bst_pkg::ST_IDLE:   state_nxt = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
        bst_pkg::ST_SEL_DR: state_nxt = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
        bst_pkg::ST_CAP_DR: state_nxt = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
        bst_pkg::ST_SH_DR:  state_nxt = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
        bst_pkg::ST_EX1_DR: state_nxt = tms ? bst_pkg::ST_UP_DR  : bst_pkg::ST_PA_DR;
        bst_pkg::ST_PA_DR:  state_nxt = tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PA_DR;
        bst_pkg::ST_EX2_DR: state_nxt = tms ? bst_pkg::ST_UP_DR  : bst_pkg::ST_SH_DR;
        bst_pkg::ST_UP_DR:  state_nxt = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
        bst_pkg::ST_SEL_IR: state_nxt = tms ? bst_pkg::ST_RESET  : bst_pkg::ST_CAP_IR;
        bst_pkg::ST_CAP_IR: state_nxt = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
        bst_pkg::ST_SH_IR:  state_nxt = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
        bst_pkg::ST_EX1_IR: state_nxt = tms ? bst_pkg::ST_UP_IR  : bst_pkg::ST_PA_IR;
        bst_pkg::ST_PA_IR:  state_nxt = tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR;
        bst_pkg::ST_EX2_IR: state_nxt = tms ? bst_pkg::ST_UP_IR  : bst_pkg::ST_SH_IR;
        bst_pkg::ST_UP_IR:  state_nxt = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      endcase
    end
    // Disabled port parks in reset so functional logic is untouched
    if (!trst_n || !enabled) begin
      state_nxt = bst_pkg::ST_RESET;
    end
  end

  // ****************************************
  // Instruction register
  // ****************************************
  logic [bst_pkg::IR_W-1:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
  always_comb begin
    ir_sh_nxt = ir_sh_r;
    ir_nxt    = ir_r;
    if (tck_rise && state_r == bst_pkg::ST_CAP_IR) begin
      ir_sh_nxt = bst_pkg::IR_CAPTURE;
    end else if (tck_rise && state_r == bst_pkg::ST_SH_IR) begin
      ir_sh_nxt = {tdi, ir_sh_r[bst_pkg::IR_W-1:1]};
    end
    if (tck_fall && state_r == bst_pkg::ST_UP_IR) begin
      ir_nxt = ir_sh_r;
    end
    if (state_r == bst_pkg::ST_RESET) begin
      ir_nxt = bst_pkg::IR_IDCODE;
    end
  end

  // ****************************************
  // Instruction decode
  // ****************************************
  function automatic logic sel_bsr(input logic [bst_pkg::IR_W-1:0] ir);
    sel_bsr = (ir == bst_pkg::IR_SAMPLE) || (ir == bst_pkg::IR_EXTEST);
  endfunction : sel_bsr

  function automatic logic sel_id(input logic [bst_pkg::IR_W-1:0] ir);
    sel_id = (ir == bst_pkg::IR_IDCODE);
  endfunction : sel_id

  // ****************************************
  // Data registers
  // ****************************************
  logic [bst_pkg::BSR_W-1:0] bsr_sh_r, bsr_sh_nxt, bsr_lat_r, bsr_lat_nxt;
  logic [bst_pkg::ID_W-1:0]  id_sh_r, id_sh_nxt, id_lat_r, id_lat_nxt;
  logic                      byp_r, byp_nxt;
  logic [bst_pkg::ID_W-1:0]  id_code;
  assign id_code = {bst_pkg::ID_VERSION, bst_pkg::ID_DEVICE,
                    bst_pkg::ID_MAKER, bst_pkg::ID_LSB};

  always_comb begin
    bsr_sh_nxt  = bsr_sh_r;
    bsr_lat_nxt = bsr_lat_r;
    id_sh_nxt   = id_sh_r;
    id_lat_nxt  = id_lat_r;
    byp_nxt     = byp_r;
    if (tck_rise && state_r == bst_pkg::ST_CAP_DR) begin
      if (sel_bsr(ir_r)) begin
        bsr_sh_nxt = bsr_pin_in;
      end else if (sel_id(ir_r)) begin
        id_sh_nxt = id_code;
      end else begin
        byp_nxt = 1'h0;
      end
    end else if (tck_rise && state_r == bst_pkg::ST_SH_DR) begin
      if (sel_bsr(ir_r)) begin
        bsr_sh_nxt = {tdi, bsr_sh_r[bst_pkg::BSR_W-1:1]};
      end else if (sel_id(ir_r)) begin
        id_sh_nxt = {tdi, id_sh_r[bst_pkg::ID_W-1:1]};
      end else begin
        byp_nxt = tdi;
      end
    end
    if (tck_fall && state_r == bst_pkg::ST_UP_DR) begin
      if (sel_bsr(ir_r)) begin
        bsr_lat_nxt = bsr_sh_r;
      end else if (sel_id(ir_r)) begin
        id_lat_nxt = id_sh_r;
      end
    end
  end

  // ****************************************
  // Serial out, changes on falling edge as the standard port does
  // ****************************************
  logic tdo_r, tdo_nxt, tdo_oe_r, tdo_oe_nxt;
  always_comb begin
    tdo_nxt    = tdo_r;
    tdo_oe_nxt = tdo_oe_r;
    if (tck_fall) begin
      tdo_oe_nxt = (state_r == bst_pkg::ST_SH_DR) || (state_r == bst_pkg::ST_SH_IR);
      if (state_r == bst_pkg::ST_SH_IR) begin
        tdo_nxt = ir_sh_r[0];
      end else if (sel_bsr(ir_r)) begin
        tdo_nxt = bsr_sh_r[0];
      end else if (sel_id(ir_r)) begin
        tdo_nxt = id_sh_r[0];
      end else begin
        tdo_nxt = byp_r;
      end
    end
    if (!enabled) begin
      tdo_oe_nxt = 1'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= bst_pkg::ST_RESET;
      ir_sh_r   <= bst_pkg::IR_IDCODE;
      ir_r      <= bst_pkg::IR_IDCODE;
      bsr_sh_r  <= '0;
      bsr_lat_r <= '0;
      id_sh_r   <= '0;
      id_lat_r  <= '0;
      byp_r     <= 1'h0;
      tdo_r     <= 1'h0;
      tdo_oe_r  <= 1'h0;
    end else begin
      state_r   <= state_nxt;
      ir_sh_r   <= ir_sh_nxt;
      ir_r      <= ir_nxt;
      bsr_sh_r  <= bsr_sh_nxt;
      bsr_lat_r <= bsr_lat_nxt;
      id_sh_r   <= id_sh_nxt;
      id_lat_r  <= id_lat_nxt;
      byp_r     <= byp_nxt;
      tdo_r     <= tdo_nxt;
      tdo_oe_r  <= tdo_oe_nxt;
    end
  end

  // ****************************************
  // Pin muxing
  // ****************************************
  logic test_drive;
  assign test_drive = (ir_r == bst_pkg::IR_EXTEST) || (ir_r == bst_pkg::IR_CLAMP);
  assign bsr_pin_out        = test_drive ? bsr_lat_r : bsr_func_out;
  assign pin_out_oe         = (ir_r != bst_pkg::IR_HIGHZ);
  assign tap_serial_out_pin = tdo_r;
  assign tap_serial_out_oe  = tdo_oe_r;
  assign current_instr      = ir_r;

  // ****************************************
  // Assertions
  // ****************************************
  sel_ir_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && trst_n && state_r == bst_pkg::ST_SEL_IR && tms)
      |=> state_r == bst_pkg::ST_RESET)
    else $error("select-IR with mode high did not reset");
  exit2_ir_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && trst_n && state_r == bst_pkg::ST_EX2_IR)
      |=> state_r == (tms ? bst_pkg::ST_UP_IR : bst_pkg::ST_SH_IR))
    else $error("exit2-IR branch wrong");
  update_next_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && trst_n && (state_r == bst_pkg::ST_UP_IR || state_r == bst_pkg::ST_UP_DR))
      |=> state_r == (tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE))
    else $error("update state branch wrong");
  cap_ir_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && state_r == bst_pkg::ST_CAP_IR) |=> ir_sh_r == bst_pkg::IR_CAPTURE)
    else $error("capture-IR value wrong");
  ir_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_fall && state_r == bst_pkg::ST_UP_IR) |=> ir_r == $past(ir_sh_r))
    else $error("instruction not latched");
  ir_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == bst_pkg::ST_SH_IR && $past(state_r) == bst_pkg::ST_SH_IR) |-> $stable(ir_r))
    else $error("instruction changed while shifting");
  reset_idcode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == bst_pkg::ST_RESET) |=> ir_r == bst_pkg::IR_IDCODE)
    else $error("reset state without idcode");
  trst_force_a: assert property (@(posedge clk) disable iff (!rst_n)
    !trst_n |=> state_r == bst_pkg::ST_RESET)
    else $error("test reset ignored");
  id_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && state_r == bst_pkg::ST_CAP_DR && sel_id(ir_r)) |=> id_sh_r == id_code)
    else $error("id code not captured");
  highz_oe_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ir_r == bst_pkg::IR_HIGHZ) |-> !pin_out_oe)
    else $error("outputs driven under highz");
  port_disabled_a: assert property (@(posedge clk) disable iff (!rst_n)
    !enabled |=> state_r == bst_pkg::ST_RESET && !tap_serial_out_oe)
    else $error("port active while disabled");
  exit1_ir_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && trst_n && state_r == bst_pkg::ST_EX1_IR)
      |=> state_r == (tms ? bst_pkg::ST_UP_IR : bst_pkg::ST_PA_IR))
    else $error("exit1-IR branch wrong");
  pause_ir_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && trst_n && state_r == bst_pkg::ST_PA_IR)
      |=> state_r == (tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR))
    else $error("pause-IR branch wrong");
  pause_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == bst_pkg::ST_PA_IR) |=> ir_sh_r == $past(ir_sh_r))
    else $error("instruction shifted while paused");
  sel_ir_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == bst_pkg::ST_SEL_IR)
      |=> ir_r == $past(ir_r) && ir_sh_r == $past(ir_sh_r) && bsr_sh_r == $past(bsr_sh_r))
    else $error("registers changed in select-IR");
  shift_ir_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && state_r == bst_pkg::ST_SH_IR)
      |=> ir_sh_r == {$past(tdi), $past(ir_sh_r[bst_pkg::IR_W-1:1])})
    else $error("instruction shift wrong");
  ir_serial_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_fall && state_r == bst_pkg::ST_SH_IR)
      |=> tap_serial_out_oe && tap_serial_out_pin == $past(ir_sh_r[0]))
    else $error("instruction bit not on serial out");
  rise_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!tck_rise && trst_n && enabled) |=> state_r == $past(state_r))
    else $error("state moved without a test clock rise");
  bsr_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && state_r == bst_pkg::ST_CAP_DR && sel_bsr(ir_r))
      |=> bsr_sh_r == $past(bsr_pin_in))
    else $error("pins not captured");
  bsr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !sel_bsr(ir_r) |=> bsr_sh_r == $past(bsr_sh_r))
    else $error("unselected boundary register moved");
  bsr_serial_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_fall && state_r == bst_pkg::ST_SH_DR && ir_r == bst_pkg::IR_SAMPLE)
      |=> tap_serial_out_pin == $past(bsr_sh_r[0]))
    else $error("boundary bit not on serial out");
  dr_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_fall && state_r == bst_pkg::ST_UP_DR && sel_bsr(ir_r))
      |=> bsr_lat_r == $past(bsr_sh_r))
    else $error("boundary latch not updated");
  extest_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ir_r == bst_pkg::IR_EXTEST) |-> pin_out_oe && bsr_pin_out == bsr_lat_r)
    else $error("extest outputs not from latches");
  clamp_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ir_r == bst_pkg::IR_CLAMP && $past(ir_r) == bst_pkg::IR_CLAMP) |-> $stable(bsr_pin_out))
    else $error("outputs changed under clamp");
  sample_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ir_r == bst_pkg::IR_SAMPLE) |-> bsr_pin_out == bsr_func_out)
    else $error("sample disturbed functional outputs");
  byp_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && state_r == bst_pkg::ST_CAP_DR && !sel_bsr(ir_r) && !sel_id(ir_r))
      |=> !byp_r)
    else $error("bypass capture not zero");
  byp_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && state_r == bst_pkg::ST_SH_DR && !sel_bsr(ir_r) && !sel_id(ir_r))
      |=> byp_r == $past(tdi))
    else $error("bypass stage did not take serial in");
  byp_serial_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_fall && state_r == bst_pkg::ST_SH_DR
      && (ir_r == bst_pkg::IR_CLAMP || ir_r == bst_pkg::IR_HIGHZ))
      |=> tap_serial_out_pin == $past(byp_r))
    else $error("bypass bit not on serial out");
  id_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && state_r == bst_pkg::ST_SH_DR && sel_id(ir_r))
      |=> id_sh_r == {$past(tdi), $past(id_sh_r[bst_pkg::ID_W-1:1])})
    else $error("id shift wrong");
  id_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tck_fall && state_r == bst_pkg::ST_UP_DR && sel_id(ir_r))
      |=> id_lat_r == $past(id_sh_r))
    else $error("id latch not updated");

  // ****************************************
  // Cover points
  // ****************************************
  c_ir_scan_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_r == bst_pkg::ST_UP_IR && tck_fall);
  c_dr_scan_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_r == bst_pkg::ST_UP_DR && tck_fall && sel_bsr(ir_r));
  c_pause_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_r == bst_pkg::ST_EX2_IR && tck_rise && !tms);
  c_extest_c: cover property (@(posedge clk) disable iff (!rst_n)
    ir_r == bst_pkg::IR_EXTEST && state_r == bst_pkg::ST_UP_DR && tck_fall);
  c_trst_c: cover property (@(posedge clk) disable iff (!rst_n)
    !trst_n && state_r == bst_pkg::ST_IDLE);

endmodule : bst_tap

// ==== bench/bst_ctl_model.sv ====
// Behavioural stand-in for the external boundary-scan test controller
`timescale 1ns/100ps
module bst_ctl_model (
  // System
  input  wire logic clk,
  // Test port pins
  output logic      tap_reset_pin_n,
  output logic      tap_clock_pin,
  output logic      tap_mode_select_pin,
  output logic      tap_serial_in_pin,
  input  wire logic tap_serial_out_pin
);
  // 10 system clocks of 4 ns per half period gives the 80 ns test clock
  localparam int HALF = 10;
  initial begin
    tap_reset_pin_n     = 1'h1;
    tap_clock_pin       = 1'h0;
    tap_mode_select_pin = 1'h1;
    tap_serial_in_pin   = 1'h0;
  end
  // One test clock period; the clock stands low outside frames
  task automatic step(input logic ms, input logic di, output logic dq);
    tap_mode_select_pin <= ms;
    tap_serial_in_pin   <= di;
    repeat (HALF) @(posedge clk);
    dq = tap_serial_out_pin;
    tap_clock_pin <= 1'h1;
    repeat (HALF) @(posedge clk);
    tap_clock_pin <= 1'h0;
  endtask : step
  task automatic move(input logic [7:0] seq, input int n);
    logic b;
    for (int i = 0; i < n; i++) begin
      step(seq[i], 1'h0, b);
    end
  endtask : move
  // Last bit leaves with mode select high, as the exit step
  task automatic scan(input logic [bst_pkg::BSR_W-1:0] din, input int n,
                      output logic [bst_pkg::BSR_W-1:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask : scan
  // Test reset is pulsed only between scans, never inside one
  task automatic treset;
    tap_reset_pin_n <= 1'h0;
    repeat (5) @(posedge clk);
    tap_reset_pin_n <= 1'h1;
    repeat (5) @(posedge clk);
  endtask : treset
endmodule : bst_ctl_model

// ==== bench/boundary_scan_tap_test.sv ====
// Self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
module boundary_scan_tap_test;
  localparam int W = bst_pkg::BSR_W;
  logic clk, rst_n, fss, trst_n, tck, tms, tdi, tdo, tdo_oe, pin_oe, tdo_line;
  logic [W-1:0] pin_in, func, pin_out, d;
  logic [2:0]   instr;
  int           err_total, n_tests;
  `define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); err_total++; end end
  bst_ctl_model ctl (.clk(clk), .tap_reset_pin_n(trst_n), .tap_clock_pin(tck),
    .tap_mode_select_pin(tms), .tap_serial_in_pin(tdi), .tap_serial_out_pin(tdo_line));
  // Undriven serial out shows the inverse of its last bit, so a missing enable corrupts reads
  assign tdo_line = tdo_oe ? tdo : ~tdo;
  bst_tap dut (.clk(clk), .rst_n(rst_n), .feature_set_select(fss),
    .tap_reset_pin_n(trst_n), .tap_clock_pin(tck), .tap_mode_select_pin(tms),
    .tap_serial_in_pin(tdi), .tap_serial_out_pin(tdo), .tap_serial_out_oe(tdo_oe),
    .bsr_pin_in(pin_in), .bsr_func_out(func), .bsr_pin_out(pin_out),
    .pin_out_oe(pin_oe), .current_instr(instr));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // ****************************************
  // Scan helpers
  // ****************************************
  task automatic dr_scan(input logic [W-1:0] din, input int n);
    ctl.move(8'h01, 3);
    ctl.scan(din, n, d);
    ctl.move(8'h01, 2);
  endtask : dr_scan
  task automatic ir_shift(input logic [2:0] code, output logic [2:0] cap);
    logic [W-1:0] v;
    ctl.move(8'h03, 4);
    ctl.scan({{(W-3){1'h0}}, code}, 3, v);
    cap = v[2:0];
    ctl.move(8'h01, 2);
  endtask : ir_shift
  task automatic ir_load(input logic [2:0] code);
    logic [2:0] cap;
    ir_shift(code, cap);
    `CHK(cap, bst_pkg::IR_CAPTURE)
    `CHK(instr, code)
  endtask : ir_load
  task automatic id_check;
    dr_scan('0, 32);
    `CHK(d[31:0], {bst_pkg::ID_VERSION, bst_pkg::ID_DEVICE, bst_pkg::ID_MAKER, 1'h1})
  endtask : id_check
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_codes;
    logic [2:0] c [6];
    c = '{bst_pkg::IR_EXTEST, bst_pkg::IR_IDCODE, bst_pkg::IR_SAMPLE,
          bst_pkg::IR_CLAMP, bst_pkg::IR_HIGHZ, bst_pkg::IR_BYPASS};
    foreach (c[i]) begin
      ir_load(c[i]);
      if (c[i] == bst_pkg::IR_IDCODE) id_check();
      if (c[i] inside {bst_pkg::IR_CLAMP, bst_pkg::IR_HIGHZ, bst_pkg::IR_BYPASS}) begin
        dr_scan({{(W-8){1'h0}}, 8'ha5}, 8);
        `CHK(d[7:0], 8'h4a)
      end
      `CHK(pin_oe, c[i] != bst_pkg::IR_HIGHZ)
      if (c[i] == bst_pkg::IR_BYPASS) `CHK(pin_out, func)
    end
  endtask : t_codes
  task automatic t_boundary;
    logic [W-1:0] p;
    p = {42{3'h5}};
    ir_load(bst_pkg::IR_SAMPLE);
    dr_scan(p, W);
    `CHK(d, pin_in)
    `CHK(pin_out, func)
    ir_load(bst_pkg::IR_EXTEST);
    `CHK(pin_out, p)
    dr_scan(~p, W);
    `CHK(d, pin_in)
    `CHK(pin_out, ~p)
    ir_load(bst_pkg::IR_CLAMP);
    `CHK(pin_out, ~p)
  endtask : t_boundary
  task automatic t_pause;
    logic b;
    ctl.move(8'h03, 4);
    ctl.step(1'h1, 1'h0, b);
    ctl.move(8'h04, 4); // Pause, stay, Exit2, back to Shift
    ctl.step(1'h0, 1'h1, b);
    ctl.step(1'h1, 1'h0, b);
    ctl.move(8'h06, 4); // Pause, Exit2, Update, Idle
    `CHK(instr, bst_pkg::IR_SAMPLE)
  endtask : t_pause
  task automatic t_resets;
    logic [2:0] cap;
    ctl.move(8'h07, 3);
    `CHK(instr, bst_pkg::IR_IDCODE)
    ctl.move(8'h00, 1);
    ir_load(bst_pkg::IR_BYPASS);
    ctl.treset();
    `CHK(instr, bst_pkg::IR_IDCODE)
    ctl.move(8'h00, 1);
    fss <= 1'h1;
    ir_shift(bst_pkg::IR_BYPASS, cap);
    `CHK(instr, bst_pkg::IR_IDCODE)
    `CHK(tdo_oe, 1'h0)
    fss <= 1'h0;
    repeat (5) @(posedge clk);
    ctl.move(8'h00, 1);
    ir_load(bst_pkg::IR_HIGHZ);
  endtask : t_resets
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  initial begin
    err_total = 0;
    n_tests   = 0;
    rst_n     = 1'h0;
    fss       = 1'h0;
    pin_in    = {63{2'h2}};
    func      = {63{2'h1}};
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    repeat (5) @(posedge clk);
    `CHK(instr, bst_pkg::IR_IDCODE)
    ctl.move(8'h00, 1);
    id_check();
    t_codes();
    t_boundary();
    t_pause();
    t_resets();
    end_of_test();
  end
endmodule : boundary_scan_tap_test
